// ===== rtl/slsce_pkg.sv
// Package of offsets, field positions and reset values for the link status and channel enable block.
package slsce_pkg;

	// ----------------------------------------------------------------
	// Register indices and byte addresses
	// ----------------------------------------------------------------
	localparam logic [11:0] STATUS_IDX    = 12'h208;
	localparam logic [11:0] CHEN_IDX      = 12'h209;
	localparam logic [11:0] IRQ_STAT_IDX  = 12'h20a;
	localparam logic [11:0] IRQ_MASK_IDX  = 12'h20b;
	localparam logic [31:0] STATUS_ADDR   = {18'h00000, STATUS_IDX, 2'b00};
	localparam logic [31:0] CHEN_ADDR     = {18'h00000, CHEN_IDX, 2'b00};
	localparam logic [31:0] IRQ_STAT_ADDR = {18'h00000, IRQ_STAT_IDX, 2'b00};
	localparam logic [31:0] IRQ_MASK_ADDR = {18'h00000, IRQ_MASK_IDX, 2'b00};

	// ----------------------------------------------------------------
	// Status register fields
	// ----------------------------------------------------------------
	localparam int          ST_LINK_UP_BIT = 6;
	localparam int          ST_SYNC_BIT    = 5;
	localparam int          ST_REALIGN_BIT = 4;
	localparam int          ST_PHASE_BIT   = 3;
	localparam int          ST_SPLL_BIT    = 2;
	localparam int          ST_CPLL_BIT    = 0;
	localparam logic [7:0]  STATUS_RESET   = 8'h00;

	// ----------------------------------------------------------------
	// Channel enable register fields
	// ----------------------------------------------------------------
	localparam int          CH_ONE_BIT     = 2;
	localparam int          CH_SECOND_BIT  = 1;
	localparam int          CH_FIRST_BIT   = 0;
	localparam logic [7:0]  CHEN_RESET     = 8'h03;

	// ----------------------------------------------------------------
	// Interrupt status and mask fields
	// ----------------------------------------------------------------
	localparam int          IRQ_W          = 4;
	localparam int          IRQ_REALIGN    = 0;
	localparam int          IRQ_PHASE      = 1;
	localparam int          IRQ_LINK_LOST  = 2;
	localparam int          IRQ_LOCK_LOST  = 3;
	localparam logic [3:0]  IRQ_RESET      = 4'h0;

	// ----------------------------------------------------------------
	// Bus and data path constants
	// ----------------------------------------------------------------
	localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
	localparam int          SAMPLE_W       = 16;

endpackage

// ===== rtl/slsce_sticky_bit.sv
// One sticky flag that hardware sets and software clears by writing a one.
`timescale 1ns/1ps
`default_nettype none

module slsce_sticky_bit (
	// Clock and reset
	input  wire logic hclk,
	input  wire logic hresetn,
	// Set and clear requests
	input  wire logic set_pulse,
	input  wire logic clr_pulse,
	// Flag
	output var  logic flag_q
);

	// A set arriving in the clearing cycle wins, so no event is lost.
	logic flag_d;
	assign flag_d = set_pulse | (flag_q & ~clr_pulse);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flag_q <= 1'b0;
		end else begin
			flag_q <= flag_d;
		end
	end

endmodule

`default_nettype wire

// ===== rtl/slsce_frame_map.sv
// Places channel samples into frame slots according to the enabled channel pairs.
`timescale 1ns/1ps
`default_nettype none

module slsce_frame_map
	import slsce_pkg::*;
(
	// Clock and reset
	input  wire logic                hclk,
	input  wire logic                hresetn,
	// Channel configuration
	input  wire logic                first_pair_enable,
	input  wire logic                second_pair_enable,
	input  wire logic                one_channel_mode_select,
	// Samples in
	input  wire logic [SAMPLE_W-1:0] sample_a,
	input  wire logic [SAMPLE_W-1:0] sample_b,
	input  wire logic [SAMPLE_W-1:0] sample_c,
	input  wire logic [SAMPLE_W-1:0] sample_d,
	// Frame slots out
	output var  logic [SAMPLE_W-1:0] slot0_q,
	output var  logic [SAMPLE_W-1:0] slot1_q,
	output var  logic [SAMPLE_W-1:0] slot2_q,
	output var  logic [SAMPLE_W-1:0] slot3_q
);

	logic [SAMPLE_W-1:0] slot0_d;
	logic [SAMPLE_W-1:0] slot1_d;
	logic [SAMPLE_W-1:0] slot2_d;
	logic [SAMPLE_W-1:0] slot3_d;
	logic                cd_shifted;

	assign cd_shifted = ~one_channel_mode_select & ~first_pair_enable;                  // [R16]

	// Outside one-channel mode, with the first pair off, C and D move into the A and B positions.
	assign slot0_d = cd_shifted ? sample_c : sample_a;                                  // [R16]
	assign slot1_d = one_channel_mode_select ? '0 : (cd_shifted ? sample_d : sample_b); // [R8]
	assign slot2_d = (one_channel_mode_select | cd_shifted | ~second_pair_enable) ? '0 : sample_c; // [R10]
	assign slot3_d = (one_channel_mode_select | cd_shifted | ~second_pair_enable) ? '0 : sample_d; // [R10]

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			slot0_q <= '0;
			slot1_q <= '0;
			slot2_q <= '0;
			slot3_q <= '0;
		end else begin
			slot0_q <= slot0_d;
			slot1_q <= slot1_d;
			slot2_q <= slot2_d;
			slot3_q <= slot3_d;
		end
	end

endmodule

`default_nettype wire

// ===== rtl/slsce_top.sv
// Link status and channel enable register bank with an AHB-Lite slave port.
//
// Behaviour
// R1: Status bit 6 follows the link-up indication.
// R2: Status bit 5 reads 0 while SYNC~ is asserted, 1 otherwise.
// R3: Bit 4 sets whenever SYSREF shifts a block, frame or multiframe clock phase.
// R4: Bit 3 sets on the first SYSREF after the link encoder is enabled.
// R5: Bits 4 and 3 are sticky; writing one clears them.
// R6: Status bit 2 follows SerDes PLL lock.
// R7: Status bit 0 follows converter PLL lock.
// R8: One-channel mode runs channel A only, disabling B, C and D.
// R9: Software keeps the first-pair enable set in one-channel mode.
// R10: Bit 1, reset 1, enables channels C and D.
// R11: Bit 0, reset 1, enables channels A and B.
// R12: Software clears calibration and link enables before changing channel enables.
// R13: Software never clears both pair enables together.
// R14: A disabled pair halves converters and halves lanes rounding up.
// R15: Odd full lane count with a pair disabled adds tail bits.
// R16: With the first pair off, C and D samples take A and B positions.
// R17: Software writes zero to reserved channel-enable bits 7:3.
// R18: Status writes never alter live bits; writing zero keeps sticky flags.
`timescale 1ns/1ps
`default_nettype none

module slsce_top
	import slsce_pkg::*;
(
	// Clock and reset
	input  wire logic                hclk,
	input  wire logic                hresetn,
	// AHB-Lite slave
	input  wire logic                hsel,
	input  wire logic [31:0]         haddr,
	input  wire logic [1:0]          htrans,
	input  wire logic                hwrite,
	input  wire logic [2:0]          hsize,
	input  wire logic [31:0]         hwdata,
	input  wire logic                hready,
	output var  logic                hreadyout,
	output var  logic                hresp,
	output var  logic [31:0]         hrdata,
	// Link and clocking status inputs
	input  wire logic                link_up,
	input  wire logic                sync_n,
	input  wire logic                link_enable,
	input  wire logic                sysref_event,
	input  wire logic                sysref_phase_shift,
	input  wire logic                serdes_pll_lock,
	input  wire logic                converter_pll_lock,
	// Link format
	input  wire logic [3:0]          full_lane_count,
	input  wire logic [3:0]          full_converter_count,
	// Channel samples
	input  wire logic [SAMPLE_W-1:0] sample_a,
	input  wire logic [SAMPLE_W-1:0] sample_b,
	input  wire logic [SAMPLE_W-1:0] sample_c,
	input  wire logic [SAMPLE_W-1:0] sample_d,
	// Channel control outputs
	output var  logic [3:0]          channel_active_q,
	output var  logic [3:0]          lane_count_q,
	output var  logic [3:0]          converter_count_q,
	output var  logic                tail_bits_q,
	// Frame slots
	output var  logic [SAMPLE_W-1:0] slot0_q,
	output var  logic [SAMPLE_W-1:0] slot1_q,
	output var  logic [SAMPLE_W-1:0] slot2_q,
	output var  logic [SAMPLE_W-1:0] slot3_q,
	// Interrupt
	output var  logic                irq_q
);

	// ----------------------------------------------------------------
	// Bus address phase capture
	// ----------------------------------------------------------------
	logic        addr_valid;
	logic        wr_pend_q;
	logic [31:0] wr_addr_q;
	logic        wr_status;
	logic        wr_chen;
	logic        wr_irq_stat;
	logic        wr_irq_mask;

	// Only whole-word single transfers come in; hsize is not decoded.
	// Every access is answered at once with OKAY, with no wait state.
	assign addr_valid = hsel & hready & (htrans == HTRANS_NONSEQ);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= '0;
		end else begin
			wr_pend_q <= addr_valid & hwrite;
			wr_addr_q <= addr_valid ? haddr : wr_addr_q;
		end
	end

	// Writes land in the data phase, one cycle after the address phase.
	assign wr_status   = wr_pend_q & (wr_addr_q == STATUS_ADDR);
	assign wr_chen     = wr_pend_q & (wr_addr_q == CHEN_ADDR);
	assign wr_irq_stat = wr_pend_q & (wr_addr_q == IRQ_STAT_ADDR);
	assign wr_irq_mask = wr_pend_q & (wr_addr_q == IRQ_MASK_ADDR);

	// ----------------------------------------------------------------
	// Live status sampling
	// ----------------------------------------------------------------
	// Each live bit passes one flop, so a read shows the pin a cycle late.
	// Just after reset these flops still read zero.
	logic link_up_q;
	logic sync_level_q;
	logic spll_lock_q;
	logic cpll_lock_q;
	logic link_enable_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			link_up_q     <= 1'b0;
			sync_level_q  <= 1'b0;
			spll_lock_q   <= 1'b0;
			cpll_lock_q   <= 1'b0;
			link_enable_q <= 1'b0;
		end else begin
			link_up_q     <= link_up;            // [R1]
			sync_level_q  <= sync_n;             // [R2]
			spll_lock_q   <= serdes_pll_lock;    // [R6]
			cpll_lock_q   <= converter_pll_lock; // [R7]
			link_enable_q <= link_enable;
		end
	end

	// ----------------------------------------------------------------
	// Multiframe phase arming
	// ----------------------------------------------------------------
	// Armed by the enable edge and spent by the first SYSREF, so later
	// SYSREF events never set the phase flag again until re-enabled.
	logic armed_q;
	logic armed_d;
	logic phase_set;

	// An enable rising together with SYSREF counts as the first event.
	// Dropping the enable rearms for the next first event.
	assign phase_set = sysref_event & link_enable & (armed_q | ~link_enable_q); // [R4]
	assign armed_d   = link_enable & ~phase_set & (armed_q | ~link_enable_q);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			armed_q <= 1'b0;
		end else begin
			armed_q <= armed_d;
		end
	end

	// ----------------------------------------------------------------
	// Sticky status flags
	// ----------------------------------------------------------------
	logic realign_flag_q;
	logic multiframe_phase_established_flag;
	logic realign_clr;
	logic phase_clr;

	// The realign flag takes every phase shift, enabled or not.
	// A zero in the written word leaves the flag alone.
	assign realign_clr = wr_status & hwdata[ST_REALIGN_BIT]; // [R5] [R18]
	assign phase_clr   = wr_status & hwdata[ST_PHASE_BIT];   // [R5] [R18]

	slsce_sticky_bit u_realign (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.set_pulse (sysref_phase_shift), // [R3]
		.clr_pulse (realign_clr),
		.flag_q    (realign_flag_q)
	);

	slsce_sticky_bit u_phase (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.set_pulse (phase_set),
		.clr_pulse (phase_clr),
		.flag_q    (multiframe_phase_established_flag)
	);

	// Live bits have no write path at all.
	// Bits 7 and 1 are reserved and read zero.
	logic [7:0] status_word;
	always_comb begin
		status_word                 = STATUS_RESET;
		status_word[ST_LINK_UP_BIT] = link_up_q;                         // [R1] [R18]
		status_word[ST_SYNC_BIT]    = sync_level_q;                      // [R2]
		status_word[ST_REALIGN_BIT] = realign_flag_q;                    // [R3]
		status_word[ST_PHASE_BIT]   = multiframe_phase_established_flag; // [R4]
		status_word[ST_SPLL_BIT]    = spll_lock_q;                       // [R6]
		status_word[ST_CPLL_BIT]    = cpll_lock_q;                       // [R7]
	end

	// ----------------------------------------------------------------
	// Channel enable register
	// ----------------------------------------------------------------
	logic [7:0] channel_pair_enable_q;
	logic [7:0] channel_pair_enable_d;
	logic       first_pair_enable;
	logic       second_pair_enable;
	logic       one_channel_mode_select;

	// Reserved bits are stored as written; software keeps them zero.
	// Clearing both pairs idles every channel and halves the counts.
	assign channel_pair_enable_d = wr_chen ? hwdata[7:0] : channel_pair_enable_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			channel_pair_enable_q <= CHEN_RESET; // [R10] [R11]
		end else begin
			channel_pair_enable_q <= channel_pair_enable_d;
		end
	end

	assign first_pair_enable       = channel_pair_enable_q[CH_FIRST_BIT];
	assign second_pair_enable      = channel_pair_enable_q[CH_SECOND_BIT];
	assign one_channel_mode_select = channel_pair_enable_q[CH_ONE_BIT];

	// ----------------------------------------------------------------
	// Channel activity and link scaling
	// ----------------------------------------------------------------
	logic [3:0] channel_active_d;
	logic       pair_reduced;
	logic [4:0] lanes_plus_one;
	logic [3:0] lane_count_d;
	logic [3:0] converter_count_d;

	// One-channel mode keeps only A; otherwise each pair follows its bit.
	assign channel_active_d[0] = first_pair_enable;                                  // [R8] [R11]
	assign channel_active_d[1] = first_pair_enable & ~one_channel_mode_select;       // [R8] [R11]
	assign channel_active_d[2] = second_pair_enable & ~one_channel_mode_select;      // [R8] [R10]
	assign channel_active_d[3] = second_pair_enable & ~one_channel_mode_select;      // [R8] [R10]

	// One-channel mode counts as reduced, as three channels stand idle.
	assign pair_reduced      = ~first_pair_enable | ~second_pair_enable | one_channel_mode_select;
	assign lanes_plus_one    = {1'b0, full_lane_count} + 5'h01;
	assign lane_count_d      = pair_reduced ? lanes_plus_one[4:1] : full_lane_count;              // [R14]
	assign converter_count_d = pair_reduced ? {1'b0, full_converter_count[3:1]} : full_converter_count; // [R14]

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			channel_active_q  <= 4'hf;
			lane_count_q      <= 4'h0;
			converter_count_q <= 4'h0;
			tail_bits_q       <= 1'b0;
		end else begin
			channel_active_q  <= channel_active_d;
			lane_count_q      <= lane_count_d;
			converter_count_q <= converter_count_d;
			tail_bits_q       <= pair_reduced & full_lane_count[0]; // [R15]
		end
	end

	// ----------------------------------------------------------------
	// Frame slot placement
	// ----------------------------------------------------------------
	// The mapper registers its slots one cycle behind the samples.
	slsce_frame_map u_frame_map (
		.hclk                    (hclk),
		.hresetn                 (hresetn),
		.first_pair_enable       (first_pair_enable),
		.second_pair_enable      (second_pair_enable),
		.one_channel_mode_select (one_channel_mode_select),
		.sample_a                (sample_a),
		.sample_b                (sample_b),
		.sample_c                (sample_c),
		.sample_d                (sample_d),
		.slot0_q                 (slot0_q),
		.slot1_q                 (slot1_q),
		.slot2_q                 (slot2_q),
		.slot3_q                 (slot3_q)
	);

	// ----------------------------------------------------------------
	// Interrupt status and mask
	// ----------------------------------------------------------------
	logic [IRQ_W-1:0] irq_event;
	logic [IRQ_W-1:0] irq_status_q;
	logic [IRQ_W-1:0] irq_mask_q;

	// Loss events fire on the falling edge only, not on a low level.
	assign irq_event[IRQ_REALIGN]   = sysref_phase_shift;
	assign irq_event[IRQ_PHASE]     = phase_set;
	assign irq_event[IRQ_LINK_LOST] = link_up_q & ~link_up;
	assign irq_event[IRQ_LOCK_LOST] = (spll_lock_q & ~serdes_pll_lock) | (cpll_lock_q & ~converter_pll_lock);

	// One sticky flag per interrupt source, cleared by writing a one.
	genvar gi;
	generate
		for (gi = 0; gi < IRQ_W; gi++) begin : g_irq
			slsce_sticky_bit u_irq_bit (
				.hclk      (hclk),
				.hresetn   (hresetn),
				.set_pulse (irq_event[gi]),
				.clr_pulse (wr_irq_stat & hwdata[gi]),
				.flag_q    (irq_status_q[gi])
			);
		end
	endgenerate

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_mask_q <= IRQ_RESET;
			irq_q      <= 1'b0;
		end else begin
			irq_mask_q <= wr_irq_mask ? hwdata[IRQ_W-1:0] : irq_mask_q;
			irq_q      <= |(irq_status_q & irq_mask_q);
		end
	end

	// ----------------------------------------------------------------
	// Read path and response
	// ----------------------------------------------------------------
	// Read data is captured in the address phase so the slave answers
	// with no wait state; unmapped addresses read zero.
	// A read meeting a write's data phase returns the older value.
	// Read data then stands until the next read is taken.
	logic [31:0] rd_word;
	logic        rd_take;

	assign rd_take = addr_valid & ~hwrite;
	assign rd_word = (haddr == STATUS_ADDR)   ? {24'h000000, status_word} :
	                 (haddr == CHEN_ADDR)     ? {24'h000000, channel_pair_enable_q} :
	                 (haddr == IRQ_STAT_ADDR) ? {28'h0000000, irq_status_q} :
	                 (haddr == IRQ_MASK_ADDR) ? {28'h0000000, irq_mask_q} :
	                 32'h00000000;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata    <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hrdata    <= rd_take ? rd_word : hrdata;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

endmodule

`default_nettype wire

// ===== testbench/slsce_chk.sv
// Checker of bus answer and channel output relations for the link status block.
`timescale 1ns/1ps
`default_nettype none

module slsce_chk
	import slsce_pkg::*;
(
	// Clock and reset
	input wire logic                hclk,
	input wire logic                hresetn,
	// Bus
	input wire logic                hsel,
	input wire logic [1:0]          htrans,
	input wire logic                hwrite,
	input wire logic                hready,
	input wire logic                hreadyout,
	input wire logic                hresp,
	input wire logic [31:0]         hrdata,
	// Link format and samples
	input wire logic [3:0]          full_lane_count,
	input wire logic [3:0]          full_converter_count,
	input wire logic [SAMPLE_W-1:0] sample_a,
	input wire logic [SAMPLE_W-1:0] sample_c,
	input wire logic [SAMPLE_W-1:0] sample_d,
	// Channel outputs
	input wire logic [3:0]          channel_active_q,
	input wire logic [3:0]          lane_count_q,
	input wire logic [3:0]          converter_count_q,
	input wire logic                tail_bits_q,
	input wire logic [SAMPLE_W-1:0] slot0_q,
	input wire logic [SAMPLE_W-1:0] slot1_q,
	input wire logic [SAMPLE_W-1:0] slot2_q,
	input wire logic [SAMPLE_W-1:0] slot3_q
);
	// ----------------------------------------------------------------
	// Helper logic
	// ----------------------------------------------------------------
	// Outputs show reset values at the first edge after release, so checks start one edge later.
	logic up_q;
	logic red;
	assign red = channel_active_q != 4'hf;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			up_q <= 1'b0;
		end else begin
			up_q <= 1'b1;
		end
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	ready_okay_a: assert property (hreadyout && !hresp)
		else $error("bus answer not ready or not okay");
	rdata_hold_a: assert property (!(hsel && hready && htrans == HTRANS_NONSEQ && !hwrite) |=> $stable(hrdata))
		else $error("read data moved without a read");
	lane_scale_a: assert property (up_q |-> lane_count_q == (red ? ({1'b0, $past(full_lane_count)} + 5'h1) >> 1
		: {1'b0, $past(full_lane_count)})) else $error("lane count wrong");
	conv_scale_a: assert property (up_q |-> converter_count_q == (red ? $past(full_converter_count) >> 1
		: $past(full_converter_count))) else $error("converter count wrong");
	tail_bits_a: assert property (up_q |-> tail_bits_q == (red && $past(full_lane_count[0])))
		else $error("tail bit flag wrong");
	pair_swap_a: assert property (up_q && channel_active_q == 4'hc |-> slot0_q == $past(sample_c) && slot2_q == '0)
		else $error("second pair not moved into first slots");
	one_chan_a: assert property (up_q && channel_active_q == 4'h1 |-> slot0_q == $past(sample_a) && slot1_q == '0)
		else $error("one channel slots wrong");
	full_slots_a: assert property (up_q && !red |-> slot3_q == $past(sample_d))
		else $error("full mode slot wrong");
endmodule

bind slsce_top slsce_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
	.hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .full_lane_count(full_lane_count),
	.full_converter_count(full_converter_count), .sample_a(sample_a), .sample_c(sample_c), .sample_d(sample_d),
	.channel_active_q(channel_active_q), .lane_count_q(lane_count_q), .converter_count_q(converter_count_q),
	.tail_bits_q(tail_bits_q), .slot0_q(slot0_q), .slot1_q(slot1_q), .slot2_q(slot2_q), .slot3_q(slot3_q));

`default_nettype wire

// ===== testbench/slsce_rx_model.sv
// Behavioural link receiver that requests resynchronisation by pulling its sync line low.
`timescale 1ns/1ps
`default_nettype none

module slsce_rx_model (
	// Clock and reset
	input  wire logic hclk,
	input  wire logic hresetn,
	// Control from the bench
	input  wire logic want_sync,
	input  wire logic slow,
	// Sync line, low while a resync is wanted
	output var  logic sync_n
);
	// A slow receiver answers one cycle later than a prompt one.
	logic [1:0] d_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			d_q <= 2'b11;
		end else begin
			d_q <= {d_q[0], !want_sync};
		end
	end
	assign sync_n = slow ? d_q[1] : d_q[0];
endmodule

`default_nettype wire

// ===== testbench/serial_link_status_channel_enable_tb.sv
// Self-checking bench of the link status and channel enable register bank.
`timescale 1ns/1ps
`default_nettype none

module serial_link_status_channel_enable_tb
	import slsce_pkg::*;
;
	logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
	logic [1:0]  htrans = 2'h0;
	logic        hready, hreadyout, hresp, irq, tail, sync_n;
	logic        link_up = 0, link_en = 0, sref = 0, sshift = 0, spll = 0, cpll = 0, want_sync = 0, slow = 0;
	logic [3:0]  lanes = 4'h5, convs = 4'h4, act, lcnt, ccnt;
	logic [15:0] sa = '0, sb = '0, sc = '0, sd = '0;
	logic [7:0]  cfg [4] = '{8'h02, 8'h01, 8'h05, 8'h03};
	int          n_errors = 0, n_compared = 0, cyc = 0;

	assign hready = hreadyout;
	initial begin
		forever #2.5 hclk = ~hclk;
	end

	slsce_rx_model u_rx (.hclk(hclk), .hresetn(hresetn), .want_sync(want_sync), .slow(slow), .sync_n(sync_n));
	slsce_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.link_up(link_up), .sync_n(sync_n), .link_enable(link_en), .sysref_event(sref),
		.sysref_phase_shift(sshift), .serdes_pll_lock(spll), .converter_pll_lock(cpll),
		.full_lane_count(lanes), .full_converter_count(convs), .sample_a(sa), .sample_b(sb), .sample_c(sc),
		.sample_d(sd), .channel_active_q(act), .lane_count_q(lcnt), .converter_count_q(ccnt),
		.tail_bits_q(tail), .slot0_q(), .slot1_q(), .slot2_q(), .slot3_q(), .irq_q(irq));

	// ----------------------------------------------------------------
	// Tasks and expectations
	// ----------------------------------------------------------------
	task automatic tally_and_finish();
		if (n_errors == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic cmp_out(input logic [3:0] got, input logic [3:0] exp);
		cmp_reg({28'h0, got}, {28'h0, exp});
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge hclk);
	endtask

	// Single transfer; entered just after a rising edge, read data lands in rd.
	task automatic ahb(input logic [31:0] a, input logic w, input logic [31:0] wd);
		haddr <= a;
		hwrite <= w;
		htrans <= HTRANS_NONSEQ;
		hsel <= 1'b1;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	task automatic pulse(input logic ev);
		if (ev) sref <= 1'b1;
		else sshift <= 1'b1;
		tick(1);
		sref <= 1'b0;
		sshift <= 1'b0;
		tick(2);
	endtask

	function automatic logic [31:0] exp_st(logic r, logic p);
		return {25'h0, link_up, !want_sync, r, p, spll, 1'b0, cpll};
	endfunction

	function automatic logic [3:0] exp_act(logic [7:0] c);
		if (c[2]) return 4'h1;
		return {c[1], c[1], c[0], c[0]};
	endfunction

	function automatic logic [3:0] exp_lane(logic [3:0] a, logic [3:0] l);
		logic [4:0] x;
		x = {1'b0, l} + 5'h1;
		return (a != 4'hf) ? x[4:1] : l;
	endfunction

	always @(posedge hclk) begin
		sa <= 16'($urandom);
		sb <= 16'($urandom);
		sc <= 16'($urandom);
		sd <= 16'($urandom);
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_errors++;
			tally_and_finish();
		end
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(54));
		tick(2);
		hresetn <= 1'b1;
		ahb(STATUS_ADDR, 1'b0, 32'h0);
		cmp_reg(rd, {24'h0, STATUS_RESET});
		ahb(CHEN_ADDR, 1'b0, 32'h0);
		cmp_reg(rd, {24'h0, CHEN_RESET});
		ahb(IRQ_MASK_ADDR, 1'b0, 32'h0);
		cmp_reg(rd, 32'h0);
		ahb(32'h900, 1'b1, 32'hff);
		ahb(32'h900, 1'b0, 32'h0);
		cmp_reg(rd, 32'h0);
		for (int i = 0; i < 8; i++) begin
			{link_up, want_sync, spll, cpll} <= 4'($urandom);
			slow <= i[0];
			tick(5);
			ahb(STATUS_ADDR, 1'b1, $urandom);
			ahb(STATUS_ADDR, 1'b0, 32'h0);
			cmp_reg(rd, exp_st(1'b0, 1'b0));
		end
		pulse(1'b0);
		ahb(STATUS_ADDR, 1'b0, 32'h0);
		cmp_reg(rd, exp_st(1'b1, 1'b0));
		ahb(STATUS_ADDR, 1'b1, 32'h08);
		ahb(STATUS_ADDR, 1'b0, 32'h0);
		cmp_reg(rd, exp_st(1'b1, 1'b0));
		ahb(STATUS_ADDR, 1'b1, 32'h10);
		ahb(STATUS_ADDR, 1'b0, 32'h0);
		cmp_reg(rd, exp_st(1'b0, 1'b0));
		pulse(1'b1);
		link_en <= 1'b1;
		tick(1);
		pulse(1'b1);
		ahb(STATUS_ADDR, 1'b0, 32'h0);
		cmp_reg(rd, exp_st(1'b0, 1'b1));
		ahb(STATUS_ADDR, 1'b1, 32'h08);
		pulse(1'b1);
		ahb(STATUS_ADDR, 1'b0, 32'h0);
		cmp_reg(rd, exp_st(1'b0, 1'b0));
		link_en <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			lanes <= {3'($urandom), i[0]};
			convs <= 4'($urandom);
			ahb(CHEN_ADDR, 1'b1, {24'h0, cfg[i]});
			ahb(CHEN_ADDR, 1'b0, 32'h0);
			cmp_reg(rd, {24'h0, cfg[i]});
			tick(1);
			cmp_out(act, exp_act(cfg[i]));
			cmp_out(lcnt, exp_lane(exp_act(cfg[i]), lanes));
			cmp_out(ccnt, (exp_act(cfg[i]) != 4'hf) ? convs >> 1 : convs);
			cmp_out({3'h0, tail}, {3'h0, exp_act(cfg[i]) != 4'hf && lanes[0]});
		end
		ahb(IRQ_STAT_ADDR, 1'b1, 32'hf);
		ahb(IRQ_MASK_ADDR, 1'b1, 32'h1);
		tick(2);
		cmp_out({3'h0, irq}, 4'h0);
		pulse(1'b0);
		cmp_out({3'h0, irq}, 4'h1);
		ahb(IRQ_MASK_ADDR, 1'b1, 32'h0);
		tick(2);
		cmp_out({3'h0, irq}, 4'h0);
		ahb(IRQ_MASK_ADDR, 1'b1, 32'h1);
		tick(2);
		cmp_out({3'h0, irq}, 4'h1);
		ahb(IRQ_STAT_ADDR, 1'b0, 32'h0);
		cmp_reg(rd, 32'h1);
		ahb(IRQ_STAT_ADDR, 1'b1, 32'h1);
		tick(2);
		cmp_out({3'h0, irq}, 4'h0);
		ahb(CHEN_ADDR, 1'b1, 32'h01);
		hresetn <= 1'b0;
		tick(2);
		hresetn <= 1'b1;
		ahb(CHEN_ADDR, 1'b0, 32'h0);
		cmp_reg(rd, {24'h0, CHEN_RESET});
		tally_and_finish();
	end
endmodule

`default_nettype wire
